/* File: hdl/tem_params.svh */
// Constants for the two-wire event enable mask block
`ifndef TEM_PARAMS_SVH
`define TEM_PARAMS_SVH

// ----------------------------------------------------------------
// Bus geometry
// ----------------------------------------------------------------
`define TEM_ADDR_W          20
`define TEM_DATA_W          32

// ----------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------
`define TEM_OFF_EVENT       20'h49300
`define TEM_OFF_INT_STATUS  20'h49304
`define TEM_OFF_NEW_EVENT   20'h49308
`define TEM_OFF_ENABLE      20'h4930c
`define TEM_OFF_IRQ_MASK    20'h49310

// ----------------------------------------------------------------
// Field positions, shared by every event-shaped register
// ----------------------------------------------------------------
`define TEM_B_SLV_REG_WR    30
`define TEM_B_SLV_REG_RD    29
`define TEM_B_SLV_TXN_DONE  28
`define TEM_B_DIAG_TIMER    26
`define TEM_B_DIAG_HIST     25
`define TEM_B_DIAG_CMD      24
`define TEM_B_IN_MBOX_WR    23
`define TEM_B_OUT_MBOX_RD   22
`define TEM_B_SLV_COL       20
`define TEM_B_SLV_TXN_TO    19
`define TEM_B_SLV_BYTE_TO   18
`define TEM_B_SLV_CLK_TO    17
`define TEM_B_MST_TXN_DONE  14
`define TEM_B_BOOT_TO       12
`define TEM_B_BOOT_ERR      11
`define TEM_B_BOOT_SIZE     10
`define TEM_B_BOOT_NODEV    9
`define TEM_B_BOOT_OK       8
`define TEM_B_MST_NACK      5
`define TEM_B_MST_COL       4
`define TEM_B_MST_TXN_TO    3
`define TEM_B_MST_BYTE_TO   2
`define TEM_B_MST_CLK_TO    1
`define TEM_B_MST_ARB_TO    0

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define TEM_RST_ENABLE      32'h74de5f3f
`define TEM_RST_EVENT       32'h00000000
`define TEM_RST_NEW_EVENT   32'h00000000
`define TEM_RST_INT_STATUS  32'h00000000
`define TEM_RST_IRQ_MASK    32'h77de5f3f
`define TEM_VALID_BITS      32'h77de5f3f

`endif

/* File: hdl/tem_pkg.sv */
// Types shared by the event enable mask block
`include "tem_params.svh"

package tem_pkg;

  // --------------------------------------------------------------
  // Carriers
  // --------------------------------------------------------------
  typedef struct packed {
    logic                    sel;
    logic                    enable;
    logic                    write;
    logic [`TEM_ADDR_W-1:0]  addr;
    logic [`TEM_DATA_W-1:0]  wdata;
  } tem_apb_req_t;

  typedef struct packed {
    logic                    wr;
    logic                    rd;
    logic [`TEM_ADDR_W-1:0]  addr;
    logic [`TEM_DATA_W-1:0]  wdata;
  } tem_acc_t;

  // --------------------------------------------------------------
  // Bus slave states
  // --------------------------------------------------------------
  typedef enum logic [1:0] {
    TEM_ST_IDLE = 2'b01,
    TEM_ST_WAIT = 2'b10
  } tem_apb_st_t;

endpackage

/* File: hdl/tem_apb_slave.sv */
// APB slave front end with one wait state for the event mask block
`timescale 1ns/10ps
`include "tem_params.svh"

module tem_apb_slave (
  // Clock and reset
  input  wire logic                    clk,
  input  wire logic                    rst_n,
  // Bus request, register read value and address match
  input  tem_pkg::tem_apb_req_t        req,
  input  wire logic [`TEM_DATA_W-1:0]  rd_value,
  input  wire logic                    addr_hit,
  // Register access strobes
  output tem_pkg::tem_acc_t            acc,
  // Bus answer
  output logic                         pready_ff,
  output logic [`TEM_DATA_W-1:0]       prdata_ff,
  output logic                         pslverr_ff
);

  tem_pkg::tem_apb_st_t state_ff;
  tem_pkg::tem_apb_st_t nxt_state;
  logic                 acc_start;
  logic                 acc_done;

  // ----------------------------------------------------------------
  // Phase decode
  // ----------------------------------------------------------------
  assign acc_start  = (state_ff == tem_pkg::TEM_ST_IDLE) & req.sel
                      & req.enable;
  assign acc_done   = (state_ff == tem_pkg::TEM_ST_WAIT) & req.sel
                      & req.enable;
  assign acc.wr     = acc_done & req.write & addr_hit;
  assign acc.rd     = acc_done & ~req.write & addr_hit;
  assign acc.addr   = req.addr;
  assign acc.wdata  = req.wdata;

  // Next state: one wait cycle, then complete
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      tem_pkg::TEM_ST_IDLE: begin
        if (acc_start) begin
          nxt_state = tem_pkg::TEM_ST_WAIT;
        end
      end
      tem_pkg::TEM_ST_WAIT: begin
        if (acc_done || !req.sel) begin
          nxt_state = tem_pkg::TEM_ST_IDLE;
        end
      end
      default: nxt_state = tem_pkg::TEM_ST_IDLE;
    endcase
  end

  // State and answer registers; read data is captured in the wait cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff   <= tem_pkg::TEM_ST_IDLE;
      pready_ff  <= 1'b0;
      prdata_ff  <= 32'h00000000;
      pslverr_ff <= 1'b0;
    end else begin
      state_ff  <= nxt_state;
      pready_ff <= acc_start;
      if (acc_start) begin
        prdata_ff  <= (!req.write && addr_hit) ? rd_value : 32'h00000000;
        pslverr_ff <= ~addr_hit;
      end else if (acc_done) begin
        pslverr_ff <= 1'b0;
      end
    end
  end

endmodule

/* File: hdl/tem_event_mask.sv */
// Event latch, enable mask and interrupt status of the two-wire controller
//
// Contract
// - An event reaches the interrupt status only if its enable bit is 1.
// - Enables for history filling (25) and command done (24) reset to 0.
// - Diagnostic timer expired enable is bit 26, read-write, reset 1.
// - Slave write done, read done, txn done enables at 30..28, reset 1.
// - Inbound mailbox write at 23, outbound mailbox read at 22, reset 1.
// - Slave collision and three slave timeouts at 20..17, reset 1.
// - Master transaction done enable is bit 14, read-write, reset 1.
// - Five boot-load enables at 12..8, read-write, reset 1.
// - Six master enables at 5..0, read-write, reset 1.
// - New-event writes of 1 set bits; event write or status read clear.
// - Soft reset clears all new-event bits and holds them clear.
`timescale 1ns/10ps
`include "tem_params.svh"

module tem_event_mask (
  // Clock and reset
  input  wire logic                    MCLK,
  input  wire logic                    RESET_N,
  // APB slave
  input  wire logic                    PSEL,
  input  wire logic                    PENABLE,
  input  wire logic                    PWRITE,
  input  wire logic [`TEM_ADDR_W-1:0]  PADDR,
  input  wire logic [`TEM_DATA_W-1:0]  PWDATA,
  output logic [`TEM_DATA_W-1:0]       PRDATA,
  output logic                         PREADY,
  output logic                         PSLVERR,
  // Event sources, one-cycle pulses from controller logic
  input  wire logic [`TEM_DATA_W-1:0]  EVENT_IN,
  // Soft reset pin
  input  wire logic                    SOFT_RESET,
  // Outputs to the rest of the controller
  output logic [`TEM_DATA_W-1:0]       ENABLE_MASK,
  output logic                         IRQ
);

  // ----------------------------------------------------------------
  // Field groups of the enable register
  // ----------------------------------------------------------------
  localparam logic [31:0] ONE       = 32'h00000001;
  localparam logic [31:0] SLV_DONE  = (ONE << `TEM_B_SLV_REG_WR)
                                    | (ONE << `TEM_B_SLV_REG_RD)
                                    | (ONE << `TEM_B_SLV_TXN_DONE);
  localparam logic [31:0] DIAG_TMR  = ONE << `TEM_B_DIAG_TIMER;
  localparam logic [31:0] DIAG_OFF  = (ONE << `TEM_B_DIAG_HIST)
                                    | (ONE << `TEM_B_DIAG_CMD);
  localparam logic [31:0] MBOX      = (ONE << `TEM_B_IN_MBOX_WR)
                                    | (ONE << `TEM_B_OUT_MBOX_RD);
  localparam logic [31:0] SLV_ERR   = (ONE << `TEM_B_SLV_COL)
                                    | (ONE << `TEM_B_SLV_TXN_TO)
                                    | (ONE << `TEM_B_SLV_BYTE_TO)
                                    | (ONE << `TEM_B_SLV_CLK_TO);
  localparam logic [31:0] MST_DONE  = ONE << `TEM_B_MST_TXN_DONE;
  localparam logic [31:0] BOOT      = (ONE << `TEM_B_BOOT_TO)
                                    | (ONE << `TEM_B_BOOT_ERR)
                                    | (ONE << `TEM_B_BOOT_SIZE)
                                    | (ONE << `TEM_B_BOOT_NODEV)
                                    | (ONE << `TEM_B_BOOT_OK);
  localparam logic [31:0] MST_ERR   = (ONE << `TEM_B_MST_NACK)
                                    | (ONE << `TEM_B_MST_COL)
                                    | (ONE << `TEM_B_MST_TXN_TO)
                                    | (ONE << `TEM_B_MST_BYTE_TO)
                                    | (ONE << `TEM_B_MST_CLK_TO)
                                    | (ONE << `TEM_B_MST_ARB_TO);

  // Fields that power up enabled and fields that power up disabled
  localparam logic [31:0] ENB_ON    = SLV_DONE
                                    | DIAG_TMR
                                    | MBOX
                                    | SLV_ERR
                                    | MST_DONE
                                    | BOOT
                                    | MST_ERR;
  localparam logic [31:0] ENB_RST   = ENB_ON & ~DIAG_OFF;
  localparam logic [31:0] VALID     = ENB_ON | DIAG_OFF;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Clear then set, so an arriving event always beats a clear
  function automatic logic [31:0] clr_set(input logic [31:0] cur,
                                          input logic [31:0] clr,
                                          input logic [31:0] set);
    clr_set = ((cur & ~clr) | set) & `TEM_VALID_BITS;
  endfunction

  // Register address match
  function automatic logic at(input logic [`TEM_ADDR_W-1:0] addr,
                              input logic [`TEM_ADDR_W-1:0] off);
    at = (addr == off);
  endfunction

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic                   rst_meta_ff;
  logic                   rst_sync_ff;
  logic                   soft_meta_ff;
  logic                   soft_sync_ff;
  logic [31:0]            enb_ff;
  logic [31:0]            irq_mask_ff;
  logic [31:0]            event_ff;
  logic [31:0]            new_evt_ff;
  logic [31:0]            status_ff;
  logic                   irq_ff;
  logic [31:0]            nxt_enb;
  logic [31:0]            nxt_irq_mask;
  logic [31:0]            nxt_event;
  logic [31:0]            nxt_new_evt;
  logic [31:0]            nxt_status;
  tem_pkg::tem_apb_req_t  apb_req;
  tem_pkg::tem_acc_t      acc;
  logic [31:0]            prdata_q;
  logic                   pready_q;
  logic                   pslverr_q;
  logic                   hit_event;
  logic                   hit_status;
  logic                   hit_new;
  logic                   hit_enb;
  logic                   hit_mask;
  logic                   addr_hit;
  logic [31:0]            rd_value;
  logic [31:0]            evt_src;
  logic [31:0]            diag_set;
  logic [31:0]            evt_w1c;
  logic                   snapshot;
  logic                   new_evt_clr;

  // ----------------------------------------------------------------
  // Reset and soft reset synchronisers
  // ----------------------------------------------------------------
  // Release of the external reset is taken through two flops
  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      rst_meta_ff <= 1'b0;
      rst_sync_ff <= 1'b0;
    end else begin
      rst_meta_ff <= 1'b1;
      rst_sync_ff <= rst_meta_ff;
    end
  end

  // Soft reset pin, two flops before any use
  always_ff @(posedge MCLK or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      soft_meta_ff <= 1'b0;
      soft_sync_ff <= 1'b0;
    end else begin
      soft_meta_ff <= SOFT_RESET;
      soft_sync_ff <= soft_meta_ff;
    end
  end

  // ----------------------------------------------------------------
  // Bus front end
  // ----------------------------------------------------------------
  assign apb_req.sel    = PSEL;
  assign apb_req.enable = PENABLE;
  assign apb_req.write  = PWRITE;
  assign apb_req.addr   = PADDR;
  assign apb_req.wdata  = PWDATA;

  tem_apb_slave u_apb (
    .clk        (MCLK),
    .rst_n      (rst_sync_ff),
    .req        (apb_req),
    .rd_value   (rd_value),
    .addr_hit   (addr_hit),
    .acc        (acc),
    .pready_ff  (pready_q),
    .prdata_ff  (prdata_q),
    .pslverr_ff (pslverr_q)
  );

  assign PRDATA  = prdata_q;
  assign PREADY  = pready_q;
  assign PSLVERR = pslverr_q;

  // ----------------------------------------------------------------
  // Address decode and read selection
  // ----------------------------------------------------------------
  assign hit_event  = at(PADDR, `TEM_OFF_EVENT);
  assign hit_status = at(PADDR, `TEM_OFF_INT_STATUS);
  assign hit_new    = at(PADDR, `TEM_OFF_NEW_EVENT);
  assign hit_enb    = at(PADDR, `TEM_OFF_ENABLE);
  assign hit_mask   = at(PADDR, `TEM_OFF_IRQ_MASK);
  assign addr_hit   = hit_event | hit_status | hit_new | hit_enb
                      | hit_mask;

  // Reserved bits are never stored, so they read back as zero
  assign rd_value = ({32{hit_event}}  & event_ff)
                  | ({32{hit_status}} & status_ff)
                  | ({32{hit_new}}    & new_evt_ff)
                  | ({32{hit_enb}}    & enb_ff)
                  | ({32{hit_mask}}   & irq_mask_ff);

  // ----------------------------------------------------------------
  // Event sources and clear terms
  // ----------------------------------------------------------------
  // Diagnostic set through the new-event register, blocked in soft reset
  assign diag_set    = (acc.wr && hit_new && !soft_sync_ff) ?
                       acc.wdata : 32'h00000000;
  assign evt_src     = (EVENT_IN | diag_set) & `TEM_VALID_BITS;
  assign evt_w1c     = (acc.wr && hit_event) ? acc.wdata : 32'h00000000;
  assign snapshot    = acc.rd & hit_status;
  assign new_evt_clr = (acc.wr & hit_event) | snapshot;

  // ----------------------------------------------------------------
  // Next values
  // ----------------------------------------------------------------
  // Enable mask: only defined fields are writable
  assign nxt_enb      = (acc.wr && hit_enb) ? (acc.wdata & VALID)
                        : enb_ff;
  assign nxt_irq_mask = (acc.wr && hit_mask) ?
                        (acc.wdata & `TEM_VALID_BITS) : irq_mask_ff;

  // Latched events, write one to clear
  assign nxt_event    = clr_set(event_ff, evt_w1c, evt_src);

  // New events since the last snapshot or event write; soft reset holds them clear
  assign nxt_new_evt  = soft_sync_ff ? 32'h00000000
                        : clr_set(new_evt_ff,
                                  {32{new_evt_clr}},
                                  evt_src);

  // Status: only enabled events set a bit, a read clears what it returned
  assign nxt_status   = clr_set(status_ff,
                                snapshot ? prdata_q : 32'h00000000,
                                evt_src & enb_ff);

  // ----------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------
  // Software-owned controls
  always_ff @(posedge MCLK or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      enb_ff      <= `TEM_RST_ENABLE;
      irq_mask_ff <= `TEM_RST_IRQ_MASK;
    end else begin
      enb_ff      <= nxt_enb;
      irq_mask_ff <= nxt_irq_mask;
    end
  end

  // Hardware-owned event state
  always_ff @(posedge MCLK or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      event_ff   <= `TEM_RST_EVENT;
      new_evt_ff <= `TEM_RST_NEW_EVENT;
      status_ff  <= `TEM_RST_INT_STATUS;
    end else begin
      event_ff   <= nxt_event;
      new_evt_ff <= nxt_new_evt;
      status_ff  <= nxt_status;
    end
  end

  // Interrupt line follows the next status so it matches the register
  always_ff @(posedge MCLK or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= |(nxt_status & nxt_irq_mask);
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign ENABLE_MASK = enb_ff;
  assign IRQ         = irq_ff;

  // Check the header reset value against the field layout
  logic unused_rst_ok;
  assign unused_rst_ok = (ENB_RST == `TEM_RST_ENABLE);

endmodule

/* File: tb/tem_event_mask_asserts.sv */
// Concurrent checks on the ports of the event enable mask block
`timescale 1ns/10ps
`include "tem_params.svh"

module tem_event_mask_chk (
  // Clock and reset
  input wire logic                    MCLK,
  input wire logic                    RESET_N,
  // APB slave
  input wire logic                    PSEL,
  input wire logic                    PENABLE,
  input wire logic                    PWRITE,
  input wire logic [`TEM_ADDR_W-1:0]  PADDR,
  input wire logic [`TEM_DATA_W-1:0]  PWDATA,
  input wire logic [`TEM_DATA_W-1:0]  PRDATA,
  input wire logic                    PREADY,
  input wire logic                    PSLVERR,
  // Event side
  input wire logic [`TEM_DATA_W-1:0]  EVENT_IN,
  input wire logic                    SOFT_RESET,
  input wire logic [`TEM_DATA_W-1:0]  ENABLE_MASK,
  input wire logic                    IRQ
);
  // ----------------------------------------------------------------
  // Transfer decode
  // ----------------------------------------------------------------
  wire done   = PSEL && PENABLE && PREADY;
  wire hit_en = (PADDR == `TEM_OFF_ENABLE);
  wire wr_en  = done && PWRITE && hit_en;
  wire mapped = (PADDR[1:0] == 2'b00) && (PADDR >= `TEM_OFF_EVENT) &&
                (PADDR <= `TEM_OFF_IRQ_MASK);
  wire cause  = (|(EVENT_IN & ENABLE_MASK)) || (PSEL && PWRITE);

  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!RESET_N);

  // ----------------------------------------------------------------
  // Enable register
  // ----------------------------------------------------------------
  AST_RST_VALUE: assert property (
    $rose(RESET_N) |-> ENABLE_MASK == `TEM_RST_ENABLE)
    else $error("enable mask not at reset value after reset");
  AST_RSVD_ZERO: assert property (
    (ENABLE_MASK & ~`TEM_VALID_BITS) == 32'h0)
    else $error("reserved enable bit set");
  AST_ENB_WRITE: assert property (
    wr_en |=> ENABLE_MASK == ($past(PWDATA) & `TEM_VALID_BITS))
    else $error("enable write not taken");
  AST_ENB_HOLD: assert property (
    !wr_en |=> $stable(ENABLE_MASK))
    else $error("enable mask changed without a write");
  AST_ENB_READ: assert property (
    done && !PWRITE && hit_en |-> PRDATA == ENABLE_MASK)
    else $error("enable read data wrong");
  // ----------------------------------------------------------------
  // Interrupt and bus answer
  // ----------------------------------------------------------------
  AST_IRQ_CAUSE: assert property (
    $rose(IRQ) |-> $past(cause) || $past(cause, 2))
    else $error("interrupt rose without an enabled event");
  AST_READY_WAIT: assert property (
    PSEL && PENABLE && !PREADY |=> PREADY)
    else $error("ready not after one wait state");
  AST_READY_PULSE: assert property (
    PREADY |-> PSEL && PENABLE ##1 !PREADY)
    else $error("ready outside access or too long");
  AST_ERR_MAP: assert property (
    done |-> PSLVERR == !mapped)
    else $error("error response does not match address map");
  AST_ERR_DATA: assert property (
    done && PSLVERR |-> PRDATA == 32'h0)
    else $error("refused read returned data");
endmodule

bind tem_event_mask tem_event_mask_chk u_chk (
  .MCLK(MCLK), .RESET_N(RESET_N), .PSEL(PSEL), .PENABLE(PENABLE),
  .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
  .PREADY(PREADY), .PSLVERR(PSLVERR), .EVENT_IN(EVENT_IN),
  .SOFT_RESET(SOFT_RESET), .ENABLE_MASK(ENABLE_MASK), .IRQ(IRQ)
);

/* File: tb/testbench.sv */
// Self-checking testbench for the event enable mask block
`timescale 1ns/10ps
`include "tem_params.svh"
`define CHK(nm, ex, got) begin n_compared++; if ((got) !== (ex)) begin \
  n_mismatch++; $display("unexpected %s exp %h got %h", nm, ex, got); end end

module testbench;
  localparam logic [31:0] VB = `TEM_VALID_BITS;
  logic        mclk       = 1'b0;
  logic        reset_n    = 1'b0;
  logic        psel       = 1'b0;
  logic        penable    = 1'b0;
  logic        pwrite     = 1'b0;
  logic [19:0] paddr      = 20'h0;
  logic [31:0] pwdata     = 32'h0;
  logic [31:0] event_in   = 32'h0;
  logic        soft_reset = 1'b0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [31:0] enable_mask;
  logic        irq;
  integer      seed       = 32'h79f83a13;
  int          n_mismatch = 0;
  int          n_compared = 0;
  logic [33:0] exp_q[$];
  logic [31:0] d;
  logic [31:0] en;
  logic [31:0] ev;

  // Clock
  always #50 mclk = ~mclk;

  tem_event_mask dut (
    .MCLK(mclk), .RESET_N(reset_n), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(pslverr), .EVENT_IN(event_in),
    .SOFT_RESET(soft_reset), .ENABLE_MASK(enable_mask), .IRQ(irq)
  );

  // ----------------------------------------------------------------
  // Bus master: note {check data, error, data}, then one transfer
  // ----------------------------------------------------------------
  task automatic apb(input logic w, input logic [19:0] a,
                     input logic [31:0] dt, input logic [33:0] note);
    int n;
    n = 0;
    exp_q.push_back(note);
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= dt;
    @(posedge mclk);
    penable <= 1'b1;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) n_mismatch++;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [19:0] a, input logic [31:0] dt);
    apb(1'b1, a, dt, 34'h0);
  endtask

  task automatic rd(input logic [19:0] a, input logic [31:0] ex);
    apb(1'b0, a, $random(seed), {2'b10, ex});
  endtask

  // Status read whose data is not checked, clears status and new events
  task automatic clr;
    apb(1'b0, `TEM_OFF_INT_STATUS, 32'h0, 34'h0);
  endtask

  // One-cycle event pulse, returns where outputs have settled
  task automatic pulse(input logic [31:0] v);
    @(posedge mclk);
    event_in <= v;
    @(posedge mclk);
    event_in <= 32'h0;
    @(negedge mclk);
  endtask

  task automatic end_sim;
    if (exp_q.size() != 0) n_mismatch++;
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Monitor: each bus answer against the oldest note
  // ----------------------------------------------------------------
  always @(posedge mclk) begin
    if (pready === 1'b1) begin
      if (exp_q.size() == 0) n_mismatch++;
      else begin
        `CHK("pslverr", exp_q[0][32], pslverr)
        if (exp_q[0][33]) `CHK("prdata", exp_q[0][31:0], prdata)
        void'(exp_q.pop_front());
      end
    end
  end

  // Watchdog against a hung handshake
  initial begin
    repeat (20000) @(posedge mclk);
    n_mismatch++;
    end_sim();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (4) @(posedge mclk);
    reset_n <= 1'b1;
    repeat (4) @(posedge mclk);
    `CHK("enable_mask", 32'h74de5f3f, enable_mask)
    rd(`TEM_OFF_ENABLE, 32'h74de5f3f);
    // Walk a single one through every enable position
    for (int i = 0; i < 32; i++) begin
      wr(`TEM_OFF_ENABLE, 32'h1 << i);
      rd(`TEM_OFF_ENABLE, (32'h1 << i) & VB);
      `CHK("enable_mask", (32'h1 << i) & VB, enable_mask)
    end
    repeat (8) begin
      d = $random(seed);
      wr(`TEM_OFF_ENABLE, d);
      rd(`TEM_OFF_ENABLE, d & VB);
    end
    // Random events against random enables
    repeat (8) begin
      en = $random(seed);
      ev = $random(seed);
      wr(`TEM_OFF_ENABLE, en);
      clr();
      pulse(ev);
      `CHK("irq", |(ev & en & VB), irq)
      rd(`TEM_OFF_NEW_EVENT, ev & VB);
      rd(`TEM_OFF_INT_STATUS, ev & en & VB);
      rd(`TEM_OFF_NEW_EVENT, 32'h0);
    end
    wr(`TEM_OFF_ENABLE, 32'h0);
    clr();
    pulse(VB);
    `CHK("irq", 1'b0, irq)
    rd(`TEM_OFF_INT_STATUS, 32'h0);
    // Interrupt raised while masked, unmasked, then cleared by read
    wr(`TEM_OFF_ENABLE, VB);
    wr(`TEM_OFF_IRQ_MASK, 32'h0);
    pulse(32'h1 << `TEM_B_MST_NACK);
    `CHK("irq", 1'b0, irq)
    wr(`TEM_OFF_IRQ_MASK, VB);
    repeat (2) @(negedge mclk);
    `CHK("irq", 1'b1, irq)
    rd(`TEM_OFF_INT_STATUS, 32'h20);
    repeat (2) @(negedge mclk);
    `CHK("irq", 1'b0, irq)
    // Set by write of ones, cleared by any event register write
    d = $random(seed);
    wr(`TEM_OFF_NEW_EVENT, d);
    rd(`TEM_OFF_NEW_EVENT, d & VB);
    wr(`TEM_OFF_EVENT, 32'h0);
    rd(`TEM_OFF_NEW_EVENT, 32'h0);
    // Soft reset clears new events and blocks every set
    wr(`TEM_OFF_NEW_EVENT, VB);
    soft_reset <= 1'b1;
    repeat (3) @(posedge mclk);
    rd(`TEM_OFF_NEW_EVENT, 32'h0);
    wr(`TEM_OFF_NEW_EVENT, VB);
    pulse(VB);
    rd(`TEM_OFF_NEW_EVENT, 32'h0);
    rd(`TEM_OFF_ENABLE, VB);
    soft_reset <= 1'b0;
    repeat (3) @(posedge mclk);
    wr(`TEM_OFF_NEW_EVENT, 32'h1);
    rd(`TEM_OFF_NEW_EVENT, 32'h1);
    // Unmapped and unaligned places are refused
    apb(1'b0, 20'h49314, 32'h0, {2'b11, 32'h0});
    apb(1'b0, 20'h4930e, 32'h0, {2'b11, 32'h0});
    apb(1'b1, 20'h49318, 32'h0, {2'b01, 32'h0});
    rd(`TEM_OFF_ENABLE, VB);
    // Let the monitor take the last answer before the verdict
    @(negedge mclk);
    end_sim();
  end
endmodule
